// ### hdl/ldc_map.vh
// register offsets, field positions, reset values and codes of the damping bank
// included by the damping register bank and its decoder
`ifndef LDC_MAP_VH
`define LDC_MAP_VH
`define LDC_ADDR_LOOP_TWO    8'h6a
`define LDC_ADDR_LOOP_ONE    8'h6b
`define LDC_RST_LOOP_TWO     8'h13
`define LDC_RST_LOOP_ONE     8'h14
`define LDC_WMASK            8'h77
`define LDC_DAMP_LSB         0
`define LDC_DAMP_MSB         2
`define LDC_GAIN_LSB         4
`define LDC_GAIN_MSB         6
// bandwidth selections
`define LDC_BW_18            2'h0
`define LDC_BW_35            2'h1
`define LDC_BW_70            2'h2
// damping factor selector, one-hot: 1.2, 2.5, 5, 10, 20
`define LDC_DF_1P2           5'h01
`define LDC_DF_2P5           5'h02
`define LDC_DF_5             5'h04
`define LDC_DF_10            5'h08
`define LDC_DF_20            5'h10
`define LDC_DF_NONE          5'h00
// gain peak in hundredths of a dB
`define LDC_PEAK_1P2         6'h28
`define LDC_PEAK_2P5         6'h14
`define LDC_PEAK_5           6'h0a
`define LDC_PEAK_10          6'h06
`define LDC_PEAK_20          6'h03
`endif

// ### hdl/ldc_damping_decode.v
// damping code decoder: code and bandwidth to damping factor and gain peak
// purely combinational; bandwidth comes from the bandwidth registers elsewhere
`timescale 1ns/1ns
`include "ldc_map.vh"
module ldc_damping_decode (
	input  wire [2:0] code,        // 3-bit damping code
	input  wire [1:0] bw_sel,      // selected loop bandwidth
	output reg  [4:0] factor,      // one-hot damping factor
	output reg  [5:0] peak,        // gain peak, 0.01 dB units
	output reg        reserved     // code 000, 110 or 111
);
	always @* begin
		reserved = 1'b0;
		case (code)
			3'h1: factor = `LDC_DF_1P2; // [R01] [R04]
			3'h2: factor = `LDC_DF_2P5;
			3'h3: factor = `LDC_DF_5;
			3'h4: factor = (bw_sel == `LDC_BW_18) ? `LDC_DF_5 : `LDC_DF_10; // [R02]
			3'h5: begin
				if (bw_sel == `LDC_BW_18)
					factor = `LDC_DF_5;
				else if (bw_sel == `LDC_BW_35)
					factor = `LDC_DF_10;
				else
					factor = `LDC_DF_20;
			end
			default: begin
				factor   = `LDC_DF_NONE;
				reserved = 1'b1; // [R07]
			end
		endcase
		case (factor) // [R03]
			`LDC_DF_1P2: peak = `LDC_PEAK_1P2;
			`LDC_DF_2P5: peak = `LDC_PEAK_2P5;
			`LDC_DF_5:   peak = `LDC_PEAK_5;
			`LDC_DF_10:  peak = `LDC_PEAK_10;
			`LDC_DF_20:  peak = `LDC_PEAK_20;
			default:     peak = 6'h00;
		endcase
	end
endmodule

// ### hdl/ldc_damping_regs.v
// What this block does
// R01: loop two codes 1,2,3 give 1.2,2.5,5
// R02: codes 4,5 depend on selected bandwidth
// R03: gain peak follows damping factor
// R04: loop one code uses same mapping
// R05: loop one bits 6:4 set 8k analog gain
// R06: loop two bits 6:4 set analog gain
// R07: bits 7,3 read zero; some codes reserved
//
// two damping configuration registers at 0x6a and 0x6b
// assumes a synchronous byte-wide register port from the serial interface
// bandwidth selections and gain enables come from neighbouring registers
// decoded factor and peak lag a field or bandwidth change by one clock
`timescale 1ns/1ns
`include "ldc_map.vh"
module ldc_damping_regs (
	input  wire       clock,                            // 50 MHz system clock
	input  wire       rst,                              // async reset, high
	input  wire [7:0] reg_addr,                         // register address
	input  wire       reg_wr,                           // write strobe
	input  wire [7:0] reg_wdata,                        // write data
	input  wire       reg_rd,                           // read strobe
	output reg  [7:0] reg_rdata,                        // read data, registered
	input  wire [1:0] loop_one_bw,                      // loop one bandwidth
	input  wire [1:0] loop_two_bw,                      // loop two bandwidth
	input  wire       loop_one_gain_enable,             // auto gain enable, loop one
	input  wire       loop_two_gain_enable,             // auto gain enable, loop two
	output wire [2:0] loop_one_damping_code,            // loop one damping code
	output wire [2:0] loop_two_damping_code,            // loop two damping code
	output wire [2:0] loop_one_detector_analog_gain_low_rate, // 8k analog gain
	output wire [2:0] loop_two_detector_analog_gain,    // analog gain
	output wire       loop_one_gain_valid,              // loop one gain applies
	output wire       loop_two_gain_valid,              // loop two gain applies
	output reg  [4:0] loop_one_factor,                  // one-hot damping factor
	output reg  [4:0] loop_two_factor,                  // one-hot damping factor
	output reg  [5:0] loop_one_peak,                    // gain peak, 0.01 dB
	output reg  [5:0] loop_two_peak,                    // gain peak, 0.01 dB
	output reg        loop_one_reserved,                // reserved code held
	output reg        loop_two_reserved                 // reserved code held
);
	localparam LOOPS    = 2;
	localparam LOOP_TWO = 0;
	localparam LOOP_ONE = 1;
	localparam CODE_W   = 3;
	localparam BW_W     = 2;
	localparam FACT_W   = 5;
	localparam PEAK_W   = 6;

	reg  [7:0]              loop_two_damping_config_reg;
	reg  [7:0]              loop_one_damping_config_reg;
	reg  [7:0]              loop_two_damping_config_next;
	reg  [7:0]              loop_one_damping_config_next;
	reg  [7:0]              reg_rdata_next;
	wire                    loop_two_hit;
	wire                    loop_one_hit;
	wire                    loop_two_wr;
	wire                    loop_one_wr;
	wire [7:0]              loop_two_read_view;
	wire [7:0]              loop_one_read_view;
	wire [LOOPS*CODE_W-1:0] code_vec;
	wire [LOOPS*BW_W-1:0]   bw_vec;
	wire [LOOPS-1:0]        enable_vec;
	wire [LOOPS-1:0]        valid_vec;
	wire [LOOPS*FACT_W-1:0] factor_vec;
	wire [LOOPS*PEAK_W-1:0] peak_vec;
	wire [LOOPS-1:0]        reserved_vec;
	wire [4:0]              f1_next;
	wire [4:0]              f2_next;
	wire [5:0]              p1_next;
	wire [5:0]              p2_next;
	wire                    r1_next;
	wire                    r2_next;

	// address compare shared by the write and read paths
	function addr_match;
		input [7:0] addr;
		input [7:0] target;
		begin
			addr_match = (addr == target);
		end
	endfunction

	// only the two 3-bit fields are kept; bits 7 and 3 stay low
	function [7:0] keep_used;
		input [7:0] value;
		begin
			keep_used = value & `LDC_WMASK;
		end
	endfunction

	function [2:0] damping_field;
		input [7:0] value;
		begin
			damping_field = value[`LDC_DAMP_MSB:`LDC_DAMP_LSB];
		end
	endfunction

	function [2:0] gain_field;
		input [7:0] value;
		begin
			gain_field = value[`LDC_GAIN_MSB:`LDC_GAIN_LSB];
		end
	endfunction

	assign loop_two_hit = addr_match(reg_addr, `LDC_ADDR_LOOP_TWO);
	assign loop_one_hit = addr_match(reg_addr, `LDC_ADDR_LOOP_ONE);
	assign loop_two_wr  = reg_wr & loop_two_hit;
	assign loop_one_wr  = reg_wr & loop_one_hit;

	// write path; other addresses leave both registers alone
	always @* begin
		loop_two_damping_config_next = loop_two_damping_config_reg;
		loop_one_damping_config_next = loop_one_damping_config_reg;
		if (loop_two_wr) begin
			loop_two_damping_config_next = keep_used(reg_wdata); // [R07]
		end
		if (loop_one_wr) begin
			loop_one_damping_config_next = keep_used(reg_wdata); // [R07]
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			loop_two_damping_config_reg <= `LDC_RST_LOOP_TWO;
		end else begin
			loop_two_damping_config_reg <= loop_two_damping_config_next;
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			loop_one_damping_config_reg <= `LDC_RST_LOOP_ONE;
		end else begin
			loop_one_damping_config_reg <= loop_one_damping_config_next;
		end
	end

	// unused bits forced low on the way out as well
	assign loop_two_read_view = keep_used(loop_two_damping_config_reg); // [R07]
	assign loop_one_read_view = keep_used(loop_one_damping_config_reg); // [R07]

	// read data held between reads; a write in the same cycle reads old value
	always @* begin
		reg_rdata_next = reg_rdata;
		if (reg_rd) begin
			if (loop_two_hit) begin
				reg_rdata_next = loop_two_read_view;
			end else if (loop_one_hit) begin
				reg_rdata_next = loop_one_read_view;
			end else begin
				reg_rdata_next = 8'h00;
			end
		end
	end

	// registered read data for the serial interface
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rdata_next;
		end
	end

	assign loop_one_damping_code = damping_field(loop_one_damping_config_reg); // [R04]
	assign loop_two_damping_code = damping_field(loop_two_damping_config_reg); // [R01]
	assign loop_one_detector_analog_gain_low_rate =
		gain_field(loop_one_damping_config_reg); // [R05]
	assign loop_two_detector_analog_gain =
		gain_field(loop_two_damping_config_reg); // [R06]

	assign code_vec   = {loop_one_damping_code, loop_two_damping_code};
	assign bw_vec     = {loop_one_bw, loop_two_bw};
	assign enable_vec = {loop_one_gain_enable, loop_two_gain_enable};

	// one decoder per loop; index 0 is loop two, index 1 is loop one
	genvar g;
	generate
		for (g = 0; g < LOOPS; g = g + 1) begin : gen_loop
			ldc_damping_decode u_dec (
				.code     (code_vec[g*CODE_W +: CODE_W]),
				.bw_sel   (bw_vec[g*BW_W +: BW_W]),
				.factor   (factor_vec[g*FACT_W +: FACT_W]),
				.peak     (peak_vec[g*PEAK_W +: PEAK_W]),
				.reserved (reserved_vec[g])
			);
			// analog gain field only applies under automatic gain selection
			assign valid_vec[g] = enable_vec[g]; // [R05] [R06]
		end
	endgenerate

	assign loop_two_gain_valid = valid_vec[LOOP_TWO]; // [R06]
	assign loop_one_gain_valid = valid_vec[LOOP_ONE]; // [R05]
	assign f2_next = factor_vec[LOOP_TWO*FACT_W +: FACT_W];
	assign f1_next = factor_vec[LOOP_ONE*FACT_W +: FACT_W];
	assign p2_next = peak_vec[LOOP_TWO*PEAK_W +: PEAK_W];
	assign p1_next = peak_vec[LOOP_ONE*PEAK_W +: PEAK_W];
	assign r2_next = reserved_vec[LOOP_TWO];
	assign r1_next = reserved_vec[LOOP_ONE];

	// decoded values registered for the loop filters
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			loop_one_factor   <= 5'h00;
			loop_two_factor   <= 5'h00;
			loop_one_peak     <= 6'h00;
			loop_two_peak     <= 6'h00;
			loop_one_reserved <= 1'b0;
			loop_two_reserved <= 1'b0;
		end else begin
			loop_one_factor   <= f1_next; // [R04] [R02]
			loop_two_factor   <= f2_next; // [R01] [R02]
			loop_one_peak     <= p1_next; // [R03] [R04]
			loop_two_peak     <= p2_next; // [R03]
			loop_one_reserved <= r1_next; // [R07]
			loop_two_reserved <= r2_next; // [R07]
		end
	end
endmodule

// ### testbench/ldc_damping_regs_props.sv
// assertions on the damping register bank
// sees only the bank's ports; attached by bind
`timescale 1ns/1ns
module ldc_damping_regs_props (
	input logic       clock,                                  // bank clock
	input logic       rst,                                    // async reset, high
	input logic       reg_wr,                                 // write strobe
	input logic       reg_rd,                                 // read strobe
	input logic [7:0] reg_addr,                               // register address
	input logic [7:0] reg_wdata,                              // write data
	input logic [7:0] reg_rdata,                              // read data
	input logic [1:0] loop_one_bw,                            // loop one bandwidth
	input logic [1:0] loop_two_bw,                            // loop two bandwidth
	input logic       loop_one_gain_enable,                   // gain enable, loop one
	input logic       loop_one_gain_valid,                    // gain applies, loop one
	input logic [2:0] loop_one_damping_code,                  // loop one code
	input logic [2:0] loop_two_damping_code,                  // loop two code
	input logic [2:0] loop_one_detector_analog_gain_low_rate, // 8k analog gain
	input logic [2:0] loop_two_detector_analog_gain,          // analog gain
	input logic [4:0] loop_one_factor,                        // loop one factor
	input logic [4:0] loop_two_factor,                        // loop two factor
	input logic [5:0] loop_one_peak,                          // loop one peak
	input logic [5:0] loop_two_peak,                          // loop two peak
	input logic       loop_one_reserved,                      // loop one reserved
	input logic       loop_two_reserved                       // loop two reserved
);
	function logic [4:0] df(logic [2:0] c, logic [1:0] b);
		df = c == 3'h1 ? 5'h01 : c == 3'h2 ? 5'h02 : c == 3'h3 ? 5'h04 :
			c == 3'h4 ? (b == 2'h0 ? 5'h04 : 5'h08) :
			c == 3'h5 ? (b == 2'h0 ? 5'h04 : b == 2'h1 ? 5'h08 : 5'h10) : 5'h00;
	endfunction
	function logic [5:0] pk(logic [4:0] f);
		pk = f[0] ? 6'h28 : f[1] ? 6'h14 : f[2] ? 6'h0a : f[3] ? 6'h06 : f[4] ? 6'h03 : 6'h00;
	endfunction
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	fixed_codes_a: assert property (loop_two_damping_code inside {3'h1, 3'h2, 3'h3} |=>
		loop_two_factor == df($past(loop_two_damping_code), 2'h0)) else $error("fixed code");
	bw_codes_a: assert property (loop_two_damping_code inside {3'h4, 3'h5} |=>
		loop_two_factor == df($past(loop_two_damping_code), $past(loop_two_bw)))
		else $error("bandwidth code");
	peak_map_a: assert property (loop_one_peak == pk(loop_one_factor) &&
		loop_two_peak == pk(loop_two_factor)) else $error("gain peak");
	one_map_a: assert property (1 |=>
		loop_one_factor == df($past(loop_one_damping_code), $past(loop_one_bw)))
		else $error("loop one factor");
	one_write_a: assert property (reg_wr && reg_addr == 8'h6b |=>
		{1'b0, loop_one_detector_analog_gain_low_rate, 1'b0, loop_one_damping_code} ==
		($past(reg_wdata) & 8'h77) && loop_one_gain_valid == loop_one_gain_enable)
		else $error("loop one write");
	two_gain_a: assert property (reg_wr && reg_addr == 8'h6a |=>
		loop_two_detector_analog_gain == $past(reg_wdata[6:4])) else $error("loop two gain");
	read_back_a: assert property (reg_rd && reg_addr == 8'h6a |=> reg_rdata ==
		{1'b0, $past(loop_two_detector_analog_gain), 1'b0, $past(loop_two_damping_code)})
		else $error("read back");
	reserved_flag_a: assert property (loop_two_damping_code inside {3'h0, 3'h6, 3'h7}
		|=> loop_two_reserved && loop_two_factor == 5'h00) else $error("reserved code");
	one_reserved_a: assert property (loop_one_damping_code inside {3'h0, 3'h6, 3'h7}
		|=> loop_one_reserved && loop_one_factor == 5'h00) else $error("loop one reserved");
endmodule
bind ldc_damping_regs ldc_damping_regs_props i_props (.*);

// ### testbench/ldc_damping_regs_tb.sv
// self-checking bench for the damping register bank
// drives the register port itself; no far-side model
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
	$display("Error %0t got %h exp %h", $time, g, e); end end
module ldc_damping_regs_tb;
	logic       clock = 0, rst = 1, reg_wr = 0, reg_rd = 0;
	logic       loop_one_gain_enable = 0, loop_two_gain_enable = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, d;
	logic [1:0] loop_one_bw = 0, loop_two_bw = 0;
	logic [2:0] loop_one_damping_code, loop_two_damping_code;
	logic [2:0] loop_one_detector_analog_gain_low_rate, loop_two_detector_analog_gain;
	logic       loop_one_gain_valid, loop_two_gain_valid, loop_one_reserved, loop_two_reserved;
	logic [4:0] loop_one_factor, loop_two_factor;
	logic [5:0] loop_one_peak, loop_two_peak;
	integer     seed = 27, mismatches = 0, samples_checked = 0, i;
	ldc_damping_regs i_dut (.*);
	function logic [4:0] df(logic [2:0] c, logic [1:0] b);
		df = c == 3'h1 ? 5'h01 : c == 3'h2 ? 5'h02 : c == 3'h3 ? 5'h04 :
			c == 3'h4 ? (b == 2'h0 ? 5'h04 : 5'h08) :
			c == 3'h5 ? (b == 2'h0 ? 5'h04 : b == 2'h1 ? 5'h08 : 5'h10) : 5'h00;
	endfunction
	function logic [5:0] pk(logic [4:0] f);
		pk = f[0] ? 6'h28 : f[1] ? 6'h14 : f[2] ? 6'h0a : f[3] ? 6'h06 : f[4] ? 6'h03 : 6'h00;
	endfunction
	task op(input logic w, input logic [7:0] a, input logic [7:0] x);
		@(posedge clock);
		#2 reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = x;
		@(posedge clock);
		#2 reg_wr = 0;
		reg_rd = 0;
	endtask
	task close_out;
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial forever #10 clock = !clock;
	initial begin
		#100000 mismatches++;
		close_out;
	end
	initial begin
		repeat (3) @(posedge clock);
		#2 rst = 0;
		op(0, 8'h6a, 8'h00); `CHK(reg_rdata, 8'h13)
		`CHK(loop_two_factor, df(3'h3, loop_two_bw))
		`CHK(loop_two_peak, 6'h0a)
		op(0, 8'h6b, 8'h00); `CHK(reg_rdata, 8'h14)
		`CHK(loop_one_factor, df(3'h4, loop_one_bw))
		op(1, 8'h6a, 8'hff);
		op(0, 8'h6a, 8'h00); `CHK(reg_rdata, 8'h77)
		`CHK(loop_two_reserved, 1'b1)
		for (i = 0; i < 64; i++) begin
			d = $random(seed);
			d[2:0] = i[2:0];
			loop_one_bw = i[4:3];
			loop_two_bw = i[5:4];
			loop_one_gain_enable = d[7];
			loop_two_gain_enable = d[3];
			op(1, 8'h6a, d);
			op(1, 8'h6b, d ^ 8'h70);
			op(1, d | 8'h80, 8'h00);
			op(0, 8'h6a, 8'h00); `CHK(reg_rdata, d & 8'h77)
			op(0, d | 8'h80, 8'h00); `CHK(reg_rdata, 8'h00)
			`CHK(loop_two_factor, df(d[2:0], loop_two_bw))
			`CHK(loop_one_factor, df(d[2:0], loop_one_bw))
			`CHK(loop_one_detector_analog_gain_low_rate, ~d[6:4])
			`CHK(loop_one_gain_valid, loop_one_gain_enable)
			`CHK(loop_two_detector_analog_gain, d[6:4])
			`CHK(loop_two_reserved, df(d[2:0], 2'h0) == 5'h00)
			`CHK(loop_one_reserved, df(d[2:0], 2'h0) == 5'h00)
			`CHK(loop_two_damping_code, d[2:0])
			`CHK(loop_one_damping_code, d[2:0])
			`CHK(loop_two_peak, pk(df(d[2:0], loop_two_bw)))
			`CHK(loop_one_peak, pk(df(d[2:0], loop_one_bw)))
			`CHK(loop_two_gain_valid, loop_two_gain_enable)
		end
		@(posedge clock);
		#2 rst = 1;
		@(posedge clock);
		#2 rst = 0;
		op(0, 8'h6b, 8'h00); `CHK(reg_rdata, 8'h14)
		`CHK(loop_one_factor, df(3'h4, loop_one_bw))
		close_out;
	end
endmodule
